/* rtl/cgc_top.v */
// clock generation control: oscillator enables, settle flags, source select
`timescale 1ns/1ps
`default_nettype none
`include "cgc_consts.vh"
module cgc_top (
  input  wire        aclk,             // system clock, 40 MHz
  input  wire        aresetn,          // sync reset, active low
  input  wire [31:0] s_axi_awaddr,     // write address
  input  wire        s_axi_awvalid,    // write address valid
  output reg         s_axi_awready,    // write address ready
  input  wire [31:0] s_axi_wdata,      // write data
  input  wire [3:0]  s_axi_wstrb,      // write strobes
  input  wire        s_axi_wvalid,     // write data valid
  output reg         s_axi_wready,     // write data ready
  output reg  [1:0]  s_axi_bresp,      // write response
  output reg         s_axi_bvalid,     // write response valid
  input  wire        s_axi_bready,     // write response ready
  input  wire [31:0] s_axi_araddr,     // read address
  input  wire        s_axi_arvalid,    // read address valid
  output reg         s_axi_arready,    // read address ready
  output reg  [31:0] s_axi_rdata,      // read data
  output reg  [1:0]  s_axi_rresp,      // read response
  output reg         s_axi_rvalid,     // read response valid
  input  wire        s_axi_rready,     // read response ready
  input  wire        independent_watchdog_en, // watchdog enabled
  input  wire [4:0]  osc_tick,         // raw ticks: fast mid slow main sub
  output reg  [4:0]  osc_run,          // oscillator enables, same order
  output reg         fast_osc_32m,     // fast oscillator at 32 MHz
  output reg  [7:0]  fast_osc_trim,    // fast oscillator trim
  output reg  [7:0]  mid_osc_trim,     // mid oscillator trim
  output reg  [7:0]  slow_osc_trim,    // slow oscillator trim
  output reg         main_osc_input_pin_ext, // main input takes digital clock
  output reg         main_osc_out_pin_oe_n,  // second pin drive enable, low drives
  output reg         main_osc_pins_port,     // pins act as port pins
  output reg         core_system_clock_en,   // core clock enable pulse
  output reg         flash_clock_en,         // flash program/erase clock enable
  output reg         clock_buzzer_output     // clock buzzer output pin
);
  // software visible controls
  reg [1:0] main_osc_input_select;
  reg       main_osc_stop_bit;
  reg       sub_stop;
  reg       fast_stop;
  reg       mid_stop;
  reg       slow_stop;
  reg [2:0] sys_req;
  reg       buz_en;
  reg [2:0] buz_src;
  reg [3:0] buz_div;
  // bus state
  reg [7:0] wr_addr;
  reg       aw_held;
  reg [31:0] wr_data;
  reg [3:0] wr_strb;
  reg       w_held;
  wire [4:0] osc_settle_status;
  wire [2:0] cur_src;
  wire       sw_busy;
  wire       core_tick;
  wire [4:0] next_run;
  wire [15:0] wait_tab [0:4];
  reg [31:0] rd_word;
  reg       rd_ok;
  reg [15:0] buz_cnt;
  reg [4:0] gated_tick;
  integer   i;

  // each oscillator runs from its own stop bit, main also needs a non-port input select; the watchdog forces slow on
  assign next_run[`CGC_SRC_FAST] = !fast_stop;
  assign next_run[`CGC_SRC_MID]  = !mid_stop;
  assign next_run[`CGC_SRC_SLOW] = !slow_stop || independent_watchdog_en;
  assign next_run[`CGC_SRC_MAIN] = !main_osc_stop_bit &&
                                   (main_osc_input_select != `CGC_MAIN_IN_PORT);
  assign next_run[`CGC_SRC_SUB]  = !sub_stop;
  assign wait_tab[0] = `CGC_WAIT_FAST;
  assign wait_tab[1] = `CGC_WAIT_MID;
  assign wait_tab[2] = `CGC_WAIT_SLOW;
  assign wait_tab[3] = `CGC_WAIT_MAIN;
  assign wait_tab[4] = `CGC_WAIT_SUB;

  // one settle timer per oscillator
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : settle
      cgc_settle u_settle (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .run      (osc_run[g]),
        .wait_len (wait_tab[g]),
        .stable   (osc_settle_status[g])
      );
    end
  endgenerate

  // ticks of unsettled oscillators never reach the switch
  always @* begin
    for (i = 0; i < 5; i = i + 1) begin
      gated_tick[i] = osc_tick[i] & osc_settle_status[i];
    end
  end

  cgc_switch u_switch (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .tick      (gated_tick),
    .req_src   (sys_req),
    .cur_src   (cur_src),
    .busy      (sw_busy),
    .core_tick (core_tick)
  );

  // register outputs to the oscillators and pins
  always @(posedge aclk) begin
    if (!aresetn) begin
      osc_run                <= 5'h01;
      main_osc_input_pin_ext <= 1'b0;
      main_osc_out_pin_oe_n  <= 1'b1;
      main_osc_pins_port     <= 1'b1;
      core_system_clock_en   <= 1'b0;
      flash_clock_en         <= 1'b0;
    end else begin
      osc_run                <= next_run;
      main_osc_input_pin_ext <= (main_osc_input_select == `CGC_MAIN_IN_EXT);
      // external clock: second pin released; crystal: second pin drives
      main_osc_out_pin_oe_n  <= (main_osc_input_select != `CGC_MAIN_IN_XTAL);
      main_osc_pins_port     <= (main_osc_input_select == `CGC_MAIN_IN_PORT);
      core_system_clock_en   <= core_tick;
      flash_clock_en         <= core_tick;
    end
  end

  // buzzer output: selected internal clock divided by a power of two
  always @(posedge aclk) begin
    if (!aresetn) begin
      buz_cnt             <= 16'h0000;
      clock_buzzer_output <= 1'b0;
    end else if (!buz_en) begin
      buz_cnt             <= 16'h0000;
      clock_buzzer_output <= 1'b0;
    end else if (buz_src <= `CGC_SRC_SUB && gated_tick[buz_src]) begin
      buz_cnt <= buz_cnt + 16'h0001;
      if (buz_div == 4'h0) begin
        clock_buzzer_output <= ~clock_buzzer_output;
      end else if (buz_cnt[buz_div - 4'h1] == 1'b1 &&
                   (buz_cnt & ((16'h0001 << (buz_div - 4'h1)) - 16'h0001)) ==
                   ((16'h0001 << (buz_div - 4'h1)) - 16'h0001)) begin
        clock_buzzer_output <= ~clock_buzzer_output;
      end
    end
  end

  // write channel: take address and data in either order, then respond
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CGC_RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      wr_addr       <= 8'h00;
      wr_data       <= 32'h00000000;
      wr_strb       <= 4'h0;
      main_osc_input_select <= `CGC_MAIN_IN_PORT;
      main_osc_stop_bit     <= `CGC_STOP_RST;
      sub_stop      <= `CGC_STOP_RST;
      mid_stop      <= `CGC_STOP_RST;
      slow_stop     <= `CGC_STOP_RST;
      fast_stop     <= `CGC_FAST_STOP_RST;
      fast_osc_32m  <= `CGC_FAST_32M_RST;
      sys_req       <= `CGC_SRC_FAST;
      buz_en        <= 1'b0;
      buz_src       <= `CGC_SRC_FAST;
      buz_div       <= 4'h0;
      fast_osc_trim <= `CGC_TRIM_RST;
      mid_osc_trim  <= `CGC_TRIM_RST;
      slow_osc_trim <= `CGC_TRIM_RST;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_awvalid && !aw_held && !s_axi_awready && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        aw_held       <= 1'b1;
        wr_addr       <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && !w_held && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
        w_held       <= 1'b1;
        wr_data      <= s_axi_wdata;
        wr_strb      <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (aw_held && w_held && !s_axi_bvalid) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `CGC_RESP_OKAY;
        if (wr_strb[0]) begin
          case (wr_addr)
            `CGC_MODE_CTRL: main_osc_input_select <= wr_data[1:0];
            `CGC_MAIN_CTRL: main_osc_stop_bit <= wr_data[0];
            `CGC_SUB_CTRL:  sub_stop  <= wr_data[0];
            `CGC_FAST_CTRL: begin
              fast_stop    <= wr_data[0];
              fast_osc_32m <= wr_data[1];
            end
            `CGC_MID_CTRL:  mid_stop  <= wr_data[0];
            `CGC_SLOW_CTRL: slow_stop <= wr_data[0];
            `CGC_SYS_SEL: begin
              // a source that is not settled is refused and the request stays
              if (wr_data[2:0] <= `CGC_SRC_SUB && osc_settle_status[wr_data[2:0]]) begin
                sys_req <= wr_data[2:0];
              end else begin
                s_axi_bresp <= `CGC_RESP_SLVERR;
              end
            end
            `CGC_BUZ_CTRL: begin
              buz_en  <= wr_data[0];
              buz_src <= wr_data[3:1];
              buz_div <= wr_data[7:4];
            end
            `CGC_FAST_TRIM: fast_osc_trim <= wr_data[7:0];
            `CGC_MID_TRIM:  mid_osc_trim  <= wr_data[7:0];
            `CGC_SLOW_TRIM: slow_osc_trim <= wr_data[7:0];
            `CGC_SETTLE_STAT, `CGC_CORE_STAT: s_axi_bresp <= `CGC_RESP_OKAY;
            default: s_axi_bresp <= `CGC_RESP_SLVERR;
          endcase
        end
      end
    end
  end

  // read mux, read back lets software confirm a frequency change
  always @* begin
    rd_ok   = 1'b1;
    rd_word = 32'h00000000;
    case (s_axi_araddr[7:0])
      `CGC_MODE_CTRL:   rd_word = {30'h00000000, main_osc_input_select};
      `CGC_MAIN_CTRL:   rd_word = {31'h00000000, main_osc_stop_bit};
      `CGC_SUB_CTRL:    rd_word = {31'h00000000, sub_stop};
      `CGC_FAST_CTRL:   rd_word = {30'h00000000, fast_osc_32m, fast_stop};
      `CGC_MID_CTRL:    rd_word = {31'h00000000, mid_stop};
      `CGC_SLOW_CTRL:   rd_word = {31'h00000000, slow_stop};
      `CGC_SETTLE_STAT: rd_word = {27'h0000000, osc_settle_status};
      `CGC_SYS_SEL:     rd_word = {29'h00000000, sys_req};
      `CGC_BUZ_CTRL:    rd_word = {24'h000000, buz_div, buz_src, buz_en};
      `CGC_FAST_TRIM:   rd_word = {24'h000000, fast_osc_trim};
      `CGC_MID_TRIM:    rd_word = {24'h000000, mid_osc_trim};
      `CGC_SLOW_TRIM:   rd_word = {24'h000000, slow_osc_trim};
      `CGC_CORE_STAT:   rd_word = {24'h000000, osc_run, sw_busy, cur_src[1:0]} |
                                  {29'h00000000, cur_src[2], 2'h0} << 6;
      default:          rd_ok   = 1'b0;
    endcase
  end

  // read channel: accept and registered data in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `CGC_RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_ok ? `CGC_RESP_OKAY : `CGC_RESP_SLVERR;
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/cgc_consts.vh */
// constants for the clock generation control block
`ifndef CGC_CONSTS_VH
`define CGC_CONSTS_VH
// register byte offsets
`define CGC_MODE_CTRL    8'h00
`define CGC_MAIN_CTRL    8'h04
`define CGC_SUB_CTRL     8'h08
`define CGC_FAST_CTRL    8'h0c
`define CGC_MID_CTRL     8'h10
`define CGC_SLOW_CTRL    8'h14
`define CGC_SETTLE_STAT  8'h18
`define CGC_SYS_SEL      8'h1c
`define CGC_BUZ_CTRL     8'h20
`define CGC_FAST_TRIM    8'h24
`define CGC_MID_TRIM     8'h28
`define CGC_SLOW_TRIM    8'h2c
`define CGC_CORE_STAT    8'h30
// source codes, also settle flag bit positions
`define CGC_SRC_FAST     3'h0
`define CGC_SRC_MID      3'h1
`define CGC_SRC_SLOW     3'h2
`define CGC_SRC_MAIN     3'h3
`define CGC_SRC_SUB      3'h4
// main oscillator input select field
`define CGC_MAIN_IN_PORT 2'h0
`define CGC_MAIN_IN_XTAL 2'h1
`define CGC_MAIN_IN_EXT  2'h3
// reset values of stop bits, frequency select and trims
`define CGC_STOP_RST     1'h1
`define CGC_FAST_STOP_RST 1'h0
`define CGC_FAST_32M_RST 1'h1
`define CGC_TRIM_RST     8'h80
// settle waits in aclk cycles
`define CGC_WAIT_FAST    16'h0040
`define CGC_WAIT_MID     16'h0020
`define CGC_WAIT_SLOW    16'h0010
`define CGC_WAIT_MAIN    16'h0100
`define CGC_WAIT_SUB     16'h0200
// axi responses
`define CGC_RESP_OKAY    2'h0
`define CGC_RESP_SLVERR  2'h2
`endif

/* rtl/cgc_settle.v */
// one oscillator settle timer: counts from start, flags stable, clears on stop
`timescale 1ns/1ps
`default_nettype none
module cgc_settle (
  input  wire        aclk,      // system clock
  input  wire        aresetn,   // sync reset, active low
  input  wire        run,       // oscillator enabled
  input  wire [15:0] wait_len,  // settle wait in cycles
  output reg         stable     // settle wait elapsed
);
  reg [15:0] count;
  // restart the wait on every stop so a brief stop cannot leave a stale flag
  always @(posedge aclk) begin
    if (!aresetn) begin
      count  <= 16'h0000;
      stable <= 1'b0;
    end else if (!run) begin
      count  <= 16'h0000;
      stable <= 1'b0;
    end else if (count == wait_len) begin
      stable <= 1'b1;
    end else begin
      count <= count + 16'h0001;
    end
  end
endmodule
`default_nettype wire

/* rtl/cgc_switch.v */
// glitch free changeover of the system clock source as an enable stream
`timescale 1ns/1ps
`default_nettype none
`include "cgc_consts.vh"
module cgc_switch (
  input  wire       aclk,       // system clock
  input  wire       aresetn,    // sync reset, active low
  input  wire [4:0] tick,       // per source one cycle ticks
  input  wire [2:0] req_src,    // requested source
  output reg  [2:0] cur_src,    // source now in use
  output reg        busy,       // changeover under way
  output reg        core_tick   // core system clock enable
);
  localparam ST_RUN  = 2'h0;
  localparam ST_OLD  = 2'h1;
  localparam ST_NEW  = 2'h2;
  reg [1:0] state;
  reg [2:0] pend;
  // wait for a tick of the old source, then a tick of the new, no tick between
  always @(posedge aclk) begin
    if (!aresetn) begin
      state     <= ST_RUN;
      cur_src   <= `CGC_SRC_FAST;
      pend      <= `CGC_SRC_FAST;
      busy      <= 1'b0;
      core_tick <= 1'b0;
    end else begin
      core_tick <= 1'b0;
      case (state)
        ST_RUN: begin
          core_tick <= tick[cur_src];
          if (req_src != cur_src) begin
            pend  <= req_src;
            busy  <= 1'b1;
            state <= ST_OLD;
          end
        end
        ST_OLD: begin
          if (tick[cur_src]) begin
            state <= ST_NEW;
          end
        end
        ST_NEW: begin
          // the suppressed ticks stretch the core period during changeover
          if (tick[pend]) begin
            cur_src   <= pend;
            core_tick <= 1'b1;
            busy      <= 1'b0;
            state     <= ST_RUN;
          end
        end
        default: state <= ST_RUN;
      endcase
    end
  end
endmodule
`default_nettype wire

/* dv/cgc_monitor.sv */
// assertion checker on the clock generation control ports
`timescale 1ns/1ps
`default_nettype none
module cgc_monitor (
  input wire logic        aclk,                    // system clock
  input wire logic        aresetn,                 // sync reset, active low
  input wire logic        s_axi_awready,           // write address ready
  input wire logic [1:0]  s_axi_bresp,             // write response
  input wire logic        s_axi_bvalid,            // write response valid
  input wire logic        s_axi_bready,            // write response ready
  input wire logic [31:0] s_axi_rdata,             // read data
  input wire logic        s_axi_rvalid,            // read valid
  input wire logic        s_axi_rready,            // read ready
  input wire logic        independent_watchdog_en, // watchdog enabled
  input wire logic [4:0]  osc_tick,                // raw ticks
  input wire logic [4:0]  osc_run,                 // oscillator enables
  input wire logic        main_osc_input_pin_ext,  // digital clock input
  input wire logic        main_osc_out_pin_oe_n,   // second pin enable
  input wire logic        main_osc_pins_port,      // pins as port pins
  input wire logic        core_system_clock_en,    // core clock enable
  input wire logic        flash_clock_en           // flash clock enable
);
  reg [7:0] since_rst; // cycles since release, saturating
  // time the fast oscillator has had to settle; saturates so it never wraps
  always @(posedge aclk) begin
    if (!aresetn)
      since_rst <= 8'h00;
    else if (since_rst != 8'hff)
      since_rst <= since_rst + 8'h01;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reset_state_a: assert property ($rose(aresetn) |-> osc_run == 5'h01 && main_osc_pins_port)
    else $error("oscillator enables wrong after reset");
  wdog_slow_a: assert property (independent_watchdog_en |=> osc_run[2])
    else $error("slow oscillator stopped while watchdog enabled");
  port_stop_a: assert property (main_osc_pins_port |-> !osc_run[3])
    else $error("main oscillator runs on port pins");
  ext_pins_a: assert property (main_osc_input_pin_ext |-> main_osc_out_pin_oe_n && !main_osc_pins_port)
    else $error("second pin driven in external clock mode");
  flash_clk_a: assert property (flash_clock_en == core_system_clock_en)
    else $error("flash clock differs from core clock");
  core_src_a: assert property (core_system_clock_en |-> $past(osc_tick, 2) != 5'h00)
    else $error("core clock pulse without a source tick");
  settle_wait_a: assert property (core_system_clock_en |-> since_rst >= 8'h40)
    else $error("core clock before fast oscillator settled");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write address ready held");
endmodule
`default_nettype wire

/* dv/cgc_osc_model.sv */
// oscillator model: per-source ticks while enabled, silent while stopped
`timescale 1ns/1ps
`default_nettype none
module cgc_osc_model (
  input  wire logic       aclk,     // system clock
  input  wire logic       aresetn,  // sync reset, active low
  input  wire logic [4:0] osc_run,  // enables from the block
  output var  logic [4:0] osc_tick  // one-cycle ticks
);
  logic [3:0] cnt [0:4];
  logic [3:0] per [0:4];
  integer     i;
  // a stopped oscillator gives no edges at all
  always @(posedge aclk) begin
    for (i = 0; i < 5; i = i + 1) begin
      if (!aresetn || !osc_run[i] || cnt[i] == per[i] - 4'h1) begin
        cnt[i] <= 4'h0;
        osc_tick[i] <= aresetn && osc_run[i];
      end else begin
        cnt[i] <= cnt[i] + 4'h1;
        osc_tick[i] <= 1'b0;
      end
    end
    // unlike periods so every changeover meets unaligned edges
    if (!aresetn) begin
      per[0] <= 4'h2;
      per[1] <= 4'h3;
      per[2] <= 4'h7;
      per[3] <= 4'h4;
      per[4] <= 4'h9;
    end else if (!osc_run[3])
      per[3] <= per[3] ^ 4'h1;
  end
endmodule
`default_nettype wire

/* dv/clock_generation_control_bench.sv */
// self-checking bench for the clock generation control block
`timescale 1ns/1ps
`default_nettype none
`include "cgc_consts.vh"
module clock_generation_control_bench;
  localparam [1:0] OK = `CGC_RESP_OKAY;
  localparam [1:0] ER = `CGC_RESP_SLVERR;
  logic        aclk, aresetn, wdt, awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] awaddr, wdata, araddr, v;
  wire         awready, wready, bvalid, arready, rvalid, f32, ext, oe_n, port, core, flash, buz;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [4:0]  tick, run;
  wire  [7:0]  trim [0:2];
  logic [1:0]  wq [$];
  logic [34:0] rq [$];
  logic [1:0]  we;
  logic [34:0] re;
  integer      miscompares, samples_checked, seed, s, n;
  logic        prev;
  cgc_top i_cgc_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .independent_watchdog_en(wdt), .osc_tick(tick), .osc_run(run), .fast_osc_32m(f32),
    .fast_osc_trim(trim[0]), .mid_osc_trim(trim[1]), .slow_osc_trim(trim[2]),
    .main_osc_input_pin_ext(ext), .main_osc_out_pin_oe_n(oe_n), .main_osc_pins_port(port),
    .core_system_clock_en(core), .flash_clock_en(flash), .clock_buzzer_output(buz));
  cgc_osc_model i_cgc_osc_model (.aclk(aclk), .aresetn(aresetn), .osc_run(run), .osc_tick(tick));
  task automatic check(input string name, input [31:0] seen, input [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // both channels offered together, each released when taken
  task automatic wr(input [7:0] a, input [31:0] d, input [1:0] r);
    wq.push_back(r);
    @(posedge aclk);
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic rd(input [7:0] a, input [31:0] d, input [1:0] r, input c);
    rq.push_back({c, r, d});
    @(posedge aclk);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
  // answers are matched against the oldest note at each handshake
  always @(posedge aclk) begin
    if (bvalid === 1'b1 && bready && wq.size() > 0) begin
      we = wq.pop_front();
      check("bresp", {30'h0, bresp}, {30'h0, we});
    end
    if (rvalid === 1'b1 && rready && rq.size() > 0) begin
      re = rq.pop_front();
      check("rresp", {30'h0, rresp}, {30'h0, re[33:32]});
      if (re[34]) check("rdata", rdata, re[31:0]);
    end
  end
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // watchdog sized well past the roughly 1200 cycles the tests need
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares = miscompares + 1;
    results;
  end
  initial begin
    {aresetn, wdt, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
    {awaddr, wdata, araddr} = 96'h0;
    miscompares = 0;
    samples_checked = 0;
    seed = 32'h21b216d0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (100) @(posedge aclk);
    rd(`CGC_CORE_STAT, 32'h08, OK, 1);
    rd(`CGC_SETTLE_STAT, 32'h01, OK, 1);
    rd(`CGC_FAST_CTRL, 32'h02, OK, 1);
    for (s = 4; s <= 8'h14; s = s + 4)
      if (s != 8'h0c) rd(s[7:0], 32'h1, OK, 1);
    for (s = 0; s < 3; s = s + 1)
      rd(`CGC_FAST_TRIM + 4 * s, 32'h80, OK, 1);
    check("pins_port", port, 1);
    $display("reset test done");
    wr(`CGC_SYS_SEL, `CGC_SRC_MAIN, ER);
    wr(`CGC_SYS_SEL, 32'h5, ER);
    wr(8'h40, 32'h0, ER);
    rd(8'h40, 32'h0, ER, 0);
    rd(`CGC_SYS_SEL, `CGC_SRC_FAST, OK, 1);
    $display("refusal test done");
    wr(`CGC_MODE_CTRL, `CGC_MAIN_IN_XTAL, OK);
    @(posedge aclk); // pin controls register one cycle after the field
    check("oe_n", {oe_n, port}, 0);
    wr(`CGC_MAIN_CTRL, 0, OK);
    wr(`CGC_SUB_CTRL, 0, OK);
    wr(`CGC_MID_CTRL, 0, OK);
    wr(`CGC_SLOW_CTRL, 0, OK);
    @(posedge aclk);
    check("osc_run", run, 5'h1f);
    repeat (600) @(posedge aclk);
    rd(`CGC_SETTLE_STAT, 32'h1f, OK, 1);
    $display("start test done");
    for (s = 4; s >= 0; s = s - 1) begin
      wr(`CGC_SYS_SEL, s, OK);
      wr(`CGC_BUZ_CTRL, {s[2:0], 1'b1}, OK);
      n = 0;
      prev = buz;
      repeat (60) begin
        @(posedge aclk);
        if (buz !== prev) n = n + 1;
        prev = buz;
      end
      check("buzzer", n != 0, 1);
      rd(`CGC_CORE_STAT, {23'h0, s[2], 6'h3e, s[1:0]}, OK, 1);
    end
    $display("switch test done");
    for (s = 0; s < 3; s = s + 1) begin
      v = $random(seed) & 32'hff;
      wr(`CGC_FAST_TRIM + 4 * s, v, OK);
      check("trim", trim[s], v);
      rd(`CGC_FAST_TRIM + 4 * s, v, OK, 1);
    end
    wr(`CGC_FAST_CTRL, 0, OK);
    check("fast_32m", f32, 0);
    wr(`CGC_FAST_CTRL, 2, OK);
    check("fast_32m", f32, 1);
    $display("trim test done");
    wr(`CGC_MODE_CTRL, `CGC_MAIN_IN_EXT, OK);
    @(posedge aclk);
    check("ext", {ext, oe_n, port}, 3'h6);
    wr(`CGC_MAIN_CTRL, 1, OK);
    @(posedge aclk);
    check("main_run", run[3], 0);
    wr(`CGC_MAIN_CTRL, 0, OK);
    wr(`CGC_SLOW_CTRL, 1, OK);
    repeat (40) @(posedge aclk) wdt <= $random(seed);
    @(posedge aclk);
    wdt <= 1'b1;
    repeat (3) @(posedge aclk);
    check("slow_wdt", run[2], 1);
    wdt <= 1'b0;
    repeat (3) @(posedge aclk);
    check("slow_stop", run[2], 0);
    $display("external test done");
    results;
  end
endmodule
bind cgc_top cgc_monitor i_cgc_monitor (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .independent_watchdog_en(independent_watchdog_en),
  .osc_tick(osc_tick), .osc_run(osc_run), .main_osc_input_pin_ext(main_osc_input_pin_ext),
  .main_osc_out_pin_oe_n(main_osc_out_pin_oe_n), .main_osc_pins_port(main_osc_pins_port),
  .core_system_clock_en(core_system_clock_en), .flash_clock_en(flash_clock_en));
`default_nettype wire
